/* shared/sbirq_pkg.sv */
// sbirq_pkg: register map, field positions and reset values of the serial bus
// interrupt/status block; assumes a 32-bit APB, registers word-aligned except the success count at FFBE
package sbirq_pkg;
  // register byte addresses (low 16 bits of paddr)
  localparam logic [15:0] ADDR_SUCCESS_COUNT = 16'hFFBE;
  localparam logic [15:0] ADDR_FLAGS         = 16'hFFC0;
  localparam logic [15:0] ADDR_SLAVE_REPORT  = 16'hFFC4;
  localparam logic [15:0] ADDR_FRAME_COUNT   = 16'hFFC8;
  localparam logic [15:0] ADDR_DATA          = 16'hFFCC;
  localparam logic [15:0] ADDR_TEL_LENGTH    = 16'hFFD0;
  // interrupt_flags bit positions
  localparam int BIT_ERR    = 6;
  localparam int BIT_START  = 5;
  localparam int BIT_STATUS = 4;
  localparam int BIT_MSGEND = 3;
  localparam int BIT_FRMEND = 2;
  // slave_report bit positions
  localparam int BIT_SR_STX  = 4;
  localparam int BIT_SR_LOCK = 2;
  localparam int BIT_SR_RX   = 1;
  localparam int BIT_SR_TX   = 0;
  localparam logic [1:0] SR_MODE = 2'h1;
  // reset and preset values
  localparam logic [8:0] SUCCESS_RESET = 9'h001;
  localparam logic [7:0] FRAME_PRESET  = 8'h20;
  localparam logic [7:0] TEL_STATUS    = 8'h01;
  localparam logic [7:0] TEL_RESET     = 8'h01;
  // status request control codes
  localparam logic [3:0] CTL_STAT0 = 4'h0;
  localparam logic [3:0] CTL_LOCK4 = 4'h4;
  localparam logic [3:0] CTL_LOCK5 = 4'h5;
  localparam logic [3:0] CTL_STAT6 = 4'h6;
  // bit timer width
  localparam int TIMER_W = 8;
endpackage

/* rtl/sbirq_core.sv */
// sbirq_core: interrupt flags, slave report and byte counters of the bus unit
// assumes a bit/field engine on pclk drives the event strobes and field bits
//
// Function
// [RULE1] error flag set by timing/underrun/parity/nack
// [RULE2] start flag on master or addressed request
// [RULE3] status flag on control codes 0,4,5,6
// [RULE4] message end at success zero, cleared by start
// [RULE5] frame end at frame zero, cleared by start
// [RULE6] bit width timer flags timing error
// [RULE7] parity error outside data or in broadcast
// [RULE8] no data parity error after lost broadcast
// [RULE9] nack in header ack slots is error
// [RULE10] late data write gives underrun error
// [RULE11] individual overrun: nack, frame counts, success not
// [RULE12] broadcast overrun: error, stop, hold rx state
// [RULE13] overrun held until data read, frame end
// [RULE14] overrun: ack header, skip data, quiet elsewhere
// [RULE15] status request presets telegraph length 01
// [RULE16] slave report mirrors stx, lock, rx, tx
// [RULE17] slave report top bits read mode 1
// [RULE18] success counter loads length, decrements on ack
// [RULE19] success counter nine bits, low eight read
// [RULE20] frame counter preset 32, decrements every slot
// [RULE21] flags ored to event irq, data irq separate
// [RULE22] write to flags clears error/start/status
// [RULE23] data irq per byte except last and 32nd; code omits it only on transmit, every stored rx byte raises it
// [RULE24] event irq pulses on any flag rising
`timescale 1ns/10ps
module sbirq_core (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // bus engine control levels
  input  wire logic        master_req_set,
  input  wire logic        slave_tx_set,
  input  wire logic        slave_rx_set,
  input  wire logic        slave_tx_enable,
  input  wire logic        locked,
  input  wire logic        broadcast,
  input  wire logic        lost_broadcast,
  input  wire logic        is_receiver,
  input  wire logic        in_data_field,
  input  wire logic        addressed,
  // bus engine events
  input  wire logic        frame_start,
  input  wire logic        addr_ack_master,
  input  wire logic        addr_slave_req,
  input  wire logic        from_lock_unit,
  input  wire logic        ctl_valid,
  input  wire logic [3:0]  ctl_code,
  input  wire logic        len_valid,
  input  wire logic [7:0]  len_rx,
  input  wire logic        bit_start,
  input  wire logic        bit_edge,
  input  wire logic [7:0]  bit_min,
  input  wire logic [7:0]  bit_max,
  input  wire logic        parity_err,
  input  wire logic        nack_hdr,
  input  wire logic        tx_load,
  input  wire logic        data_ack_slot,
  input  wire logic        data_acked,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  // bus engine answers
  output logic             hold_ack,
  output logic             rx_stop,
  output logic [7:0]       tx_byte,
  // interrupts
  output logic             data_irq,
  output logic             event_irq
);
  logic [4:0] flags_reg;
  logic [4:0] flags_next;
  logic [8:0] success_reg;
  logic [7:0] frame_reg;
  logic [7:0] tel_len_reg;
  logic [7:0] data_reg;
  logic       rx_full_reg;
  logic       tx_empty_reg;
  logic       overrun_reg;
  logic [7:0] timer_reg;
  logic       ack_reg;
  logic [31:0] rdata_next;
  logic       wr_acc;
  logic       rd_acc;
  logic       flags_wr;
  logic       data_rd;
  logic       data_wr;
  logic       restart;
  logic       timing_err;
  logic       par_irq;
  logic       underrun;
  logic       ovr_bcast;
  logic       status_req;
  logic       start_ev;
  logic       succ_dec;
  logic       rx_store;
  logic       last_byte;
  logic       frame_last;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign wr_acc   = psel && penable && pwrite;
  assign rd_acc   = psel && penable && !pwrite;
  assign flags_wr = wr_acc && (paddr[15:0] == sbirq_pkg::ADDR_FLAGS);
  assign data_wr  = wr_acc && (paddr[15:0] == sbirq_pkg::ADDR_DATA);
  assign data_rd  = rd_acc && (paddr[15:0] == sbirq_pkg::ADDR_DATA);
  assign restart  = master_req_set || slave_tx_set || slave_rx_set;

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (paddr[15:0])
      sbirq_pkg::ADDR_SUCCESS_COUNT: rdata_next[7:0] = success_reg[7:0]; // [RULE19]
      sbirq_pkg::ADDR_FLAGS:         rdata_next[6:2] = flags_reg;
      sbirq_pkg::ADDR_SLAVE_REPORT: begin
        rdata_next[7:6] = sbirq_pkg::SR_MODE; // [RULE17]
        rdata_next[sbirq_pkg::BIT_SR_STX]  = slave_tx_enable; // [RULE16]
        rdata_next[sbirq_pkg::BIT_SR_LOCK] = locked;
        rdata_next[sbirq_pkg::BIT_SR_RX]   = rx_full_reg;
        rdata_next[sbirq_pkg::BIT_SR_TX]   = !tx_empty_reg; // high while a byte waits
      end
      sbirq_pkg::ADDR_FRAME_COUNT:   rdata_next[7:0] = frame_reg;
      sbirq_pkg::ADDR_DATA:          rdata_next[7:0] = data_reg;
      sbirq_pkg::ADDR_TEL_LENGTH:    rdata_next[7:0] = tel_len_reg;
      default:                       rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error sources
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_reg <= 8'h00;
    end else if (bit_start || bit_edge) begin
      timer_reg <= 8'h00;
    end else if (timer_reg != 8'hFF) begin
      timer_reg <= timer_reg + 8'h01; // [RULE6]
    end
  end

  assign timing_err = bit_edge && ((timer_reg < bit_min) || (timer_reg > bit_max)); // [RULE6]
  assign par_irq    = parity_err && is_receiver && (addressed || !overrun_reg) &&
                      (!in_data_field || (broadcast && !lost_broadcast)); // [RULE7] [RULE8]
  assign underrun   = tx_load && in_data_field && tx_empty_reg && !is_receiver; // [RULE10]
  assign ovr_bcast  = rx_byte_valid && rx_full_reg && is_receiver && broadcast && addressed; // [RULE12]
  assign status_req = ctl_valid && !addr_ack_master &&
                      ((ctl_code == sbirq_pkg::CTL_STAT0) || (ctl_code == sbirq_pkg::CTL_LOCK4) ||
                       (ctl_code == sbirq_pkg::CTL_LOCK5) || (ctl_code == sbirq_pkg::CTL_STAT6)); // [RULE3]
  assign start_ev   = addr_ack_master || (addr_slave_req && (!locked || from_lock_unit)); // [RULE2]

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags, set wins over clear
  always_comb begin
    flags_next = flags_reg;
    if (flags_wr) begin
      flags_next[sbirq_pkg::BIT_ERR-2]    = 1'b0; // [RULE22]
      flags_next[sbirq_pkg::BIT_START-2]  = 1'b0;
      flags_next[sbirq_pkg::BIT_STATUS-2] = 1'b0;
    end
    if (restart) begin
      flags_next[sbirq_pkg::BIT_MSGEND-2] = 1'b0; // [RULE4]
      flags_next[sbirq_pkg::BIT_FRMEND-2] = 1'b0; // [RULE5]
    end
    if (timing_err || par_irq || (nack_hdr && !is_receiver) || underrun || ovr_bcast)
      flags_next[sbirq_pkg::BIT_ERR-2] = 1'b1; // [RULE1] [RULE9]
    if (start_ev)
      flags_next[sbirq_pkg::BIT_START-2] = 1'b1; // [RULE2]
    if (status_req)
      flags_next[sbirq_pkg::BIT_STATUS-2] = 1'b1; // [RULE3]
    if (succ_dec && (success_reg == 9'h001))
      flags_next[sbirq_pkg::BIT_MSGEND-2] = 1'b1; // [RULE4] [RULE18]
    if (data_ack_slot && (frame_reg == 8'h01))
      flags_next[sbirq_pkg::BIT_FRMEND-2] = 1'b1; // [RULE5] [RULE13]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= 5'h00;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_irq <= 1'b0;
    end else begin
      event_irq <= |(flags_next & ~flags_reg); // [RULE21] [RULE24]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters
  assign succ_dec = data_ack_slot && data_acked && !(overrun_reg && is_receiver); // [RULE11]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      success_reg <= sbirq_pkg::SUCCESS_RESET;
    end else if (len_valid || status_req) begin
      success_reg <= (len_rx == 8'h00 && !status_req) ? 9'h100 :
                     {1'b0, (status_req ? sbirq_pkg::TEL_STATUS : len_rx)}; // [RULE18] [RULE19]
    end else if (succ_dec && (success_reg != 9'h000)) begin
      success_reg <= success_reg - 9'h001; // [RULE18]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_reg <= sbirq_pkg::FRAME_PRESET;
    end else if (frame_start) begin
      frame_reg <= sbirq_pkg::FRAME_PRESET; // [RULE20]
    end else if (data_ack_slot && (frame_reg != 8'h00)) begin
      frame_reg <= frame_reg - 8'h01; // [RULE20] [RULE11]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tel_len_reg <= sbirq_pkg::TEL_RESET;
    end else if (status_req) begin
      tel_len_reg <= sbirq_pkg::TEL_STATUS; // [RULE15]
    end else if (len_valid) begin
      tel_len_reg <= len_rx;
    end else if (wr_acc && (paddr[15:0] == sbirq_pkg::ADDR_TEL_LENGTH)) begin
      tel_len_reg <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data register and overrun
  assign rx_store = rx_byte_valid && is_receiver && addressed && !overrun_reg && !rx_full_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg     <= 8'h00;
      rx_full_reg  <= 1'b0;
      tx_empty_reg <= 1'b1;
    end else begin
      if (rx_store) begin
        data_reg    <= rx_byte; // [RULE14]
        rx_full_reg <= 1'b1;
      end else if (data_wr) begin
        data_reg    <= pwdata[7:0];
      end
      if (ovr_bcast)
        rx_full_reg <= 1'b1; // [RULE12]
      else if (data_rd && !rx_store)
        rx_full_reg <= 1'b0;
      if (tx_load)
        tx_empty_reg <= 1'b1;
      else if (data_wr)
        tx_empty_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_reg <= 1'b0;
    end else if (rx_byte_valid && is_receiver && addressed && rx_full_reg) begin
      overrun_reg <= 1'b1; // [RULE13]
    end else if (rx_byte_valid && !rx_full_reg) begin
      overrun_reg <= 1'b0; // [RULE12]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ack <= 1'b0;
      rx_stop  <= 1'b0;
      tx_byte  <= 8'h00;
    end else begin
      hold_ack <= in_data_field && (overrun_reg || rx_full_reg) && is_receiver; // [RULE11] [RULE14]
      rx_stop  <= ovr_bcast || (rx_stop && !frame_start); // [RULE12]
      if (tx_load)
        tx_byte <= data_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data interrupt
  assign last_byte  = (success_reg == 9'h001);
  assign frame_last = (frame_reg == 8'h01);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_irq <= 1'b0;
    end else begin
      data_irq <= (tx_load && !last_byte && !frame_last) || rx_store; // [RULE21] [RULE23]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_err_on_timing;
    @(posedge pclk) disable iff (!presetn) timing_err |=> flags_reg[sbirq_pkg::BIT_ERR-2];
  endproperty
  a_err_on_timing: assert property (p_err_on_timing) else $error("timing err lost"); // [RULE6]

  property p_msg_clear;
    @(posedge pclk) disable iff (!presetn)
      (restart && !(succ_dec && success_reg == 9'h001)) |=> !flags_reg[sbirq_pkg::BIT_MSGEND-2];
  endproperty
  a_msg_clear: assert property (p_msg_clear) else $error("msg end not cleared"); // [RULE4]

  property p_frame_dec;
    @(posedge pclk) disable iff (!presetn)
      (data_ack_slot && !frame_start && frame_reg != 8'h00) |=> frame_reg == $past(frame_reg) - 8'h01;
  endproperty
  a_frame_dec: assert property (p_frame_dec) else $error("frame count not decremented"); // [RULE20]

  property p_frame_end;
    @(posedge pclk) disable iff (!presetn)
      (data_ack_slot && frame_reg == 8'h01) |=> flags_reg[sbirq_pkg::BIT_FRMEND-2] &&
        (event_irq || $past(flags_reg[sbirq_pkg::BIT_FRMEND-2]));
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame end missing"); // [RULE5]

  property p_ovr_hold;
    @(posedge pclk) disable iff (!presetn)
      (overrun_reg && data_ack_slot && is_receiver) |=> success_reg == $past(success_reg);
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("success moved in overrun"); // [RULE11]

  property p_status_len;
    @(posedge pclk) disable iff (!presetn) status_req |=> tel_len_reg == sbirq_pkg::TEL_STATUS;
  endproperty
  a_status_len: assert property (p_status_len) else $error("length not preset"); // [RULE15]

  property p_clear_flags;
    @(posedge pclk) disable iff (!presetn)
      (flags_wr && !start_ev) |=> !flags_reg[sbirq_pkg::BIT_START-2];
  endproperty
  a_clear_flags: assert property (p_clear_flags) else $error("start flag not cleared"); // [RULE22]

  property p_irq_rise;
    @(posedge pclk) disable iff (!presetn)
      (flags_reg != 5'h00 && $past(flags_reg) == 5'h00) |-> event_irq;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("no event pulse"); // [RULE24]

  property p_no_data_irq_ovr;
    @(posedge pclk) disable iff (!presetn) ovr_bcast |=> !data_irq;
  endproperty
  a_no_data_irq_ovr: assert property (p_no_data_irq_ovr) else $error("data irq in overrun"); // [RULE12]

endmodule // sbirq_core

/* dv/sbirq_bus_model.sv */
// sbirq_bus_model: far-side bus engine that strobes field events into the core
// assumes pclk from the bench and tasks called from the bench's pclk process
`timescale 1ns/10ps
module sbirq_bus_model (
  // clock
  input  wire logic  pclk,
  // levels
  output logic       slave_tx_enable,
  output logic       locked,
  output logic       broadcast,
  output logic       lost_broadcast,
  output logic       is_receiver,
  output logic       in_data_field,
  output logic       addressed,
  output logic       from_lock_unit,
  output logic       data_acked,
  // strobes
  output logic       frame_start,
  output logic       addr_ack_master,
  output logic       addr_slave_req,
  output logic       ctl_valid,
  output logic       len_valid,
  output logic       bit_start,
  output logic       bit_edge,
  output logic       parity_err,
  output logic       nack_hdr,
  output logic       tx_load,
  output logic       data_ack_slot,
  output logic       rx_byte_valid,
  output logic       master_req_set,
  output logic       slave_tx_set,
  output logic       slave_rx_set,
  // field data
  output logic [3:0] ctl_code,
  output logic [7:0] len_rx,
  output logic [7:0] rx_byte,
  output logic [7:0] bit_min,
  output logic [7:0] bit_max
);
  logic [8:0]  lv  = 9'h000;
  logic [14:0] st  = 15'h0000;
  logic [7:0]  val = 8'h00;
  ////////////////////////////////////////
  assign {slave_tx_enable, locked, broadcast, lost_broadcast, is_receiver, in_data_field,
          addressed, from_lock_unit, data_acked} = lv;
  assign {slave_rx_set, slave_tx_set, master_req_set, rx_byte_valid, data_ack_slot,
          tx_load, nack_hdr, parity_err, bit_edge, bit_start, len_valid, ctl_valid,
          addr_slave_req, addr_ack_master, frame_start} = st;
  // field data valid only with its strobe, inverted after
  assign ctl_code = val[3:0];
  assign len_rx   = val;
  assign rx_byte  = val;
  // bit width limits of the timer
  assign bit_min  = 8'h05;
  assign bit_max  = 8'h0A;
  ////////////////////////////////////////
  task automatic set_lv(input logic [8:0] v);
    @(posedge pclk);
    lv <= v;
  endtask
  // one-cycle event strobe
  task automatic pulse(input int unsigned which, input logic [7:0] v);
    @(posedge pclk);
    st  <= 15'h0001 << which;
    val <= v;
    @(posedge pclk);
    st  <= 15'h0000;
    val <= ~v;
  endtask
  // bit of w cycles between start and edge
  task automatic bit_run(input int unsigned w);
    pulse(5, 8'h00);
    repeat (w - 2) @(posedge pclk);
    pulse(6, 8'h00);
  endtask
endmodule // sbirq_bus_model

/* dv/serial_bus_irq_status_counters_test.sv */
// serial_bus_irq_status_counters_test: table and hand checks of sbirq_core
// assumes sbirq_pkg, sbirq_core and sbirq_bus_model compiled first
`timescale 1ns/10ps
module serial_bus_irq_status_counters_test;
  typedef struct packed {
    logic [8:0] lv;
    logic [3:0] ev;
    logic [7:0] v;
    logic [7:0] fl;
  } sbirq_row_t;
  localparam logic [15:0] A_SC = sbirq_pkg::ADDR_SUCCESS_COUNT;
  localparam logic [15:0] A_FL = sbirq_pkg::ADDR_FLAGS;
  localparam logic [15:0] A_SR = sbirq_pkg::ADDR_SLAVE_REPORT;
  localparam logic [15:0] A_FC = sbirq_pkg::ADDR_FRAME_COUNT;
  localparam logic [15:0] A_DT = sbirq_pkg::ADDR_DATA;
  localparam logic [15:0] A_TL = sbirq_pkg::ADDR_TEL_LENGTH;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] paddr   = 32'h0000_0000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic        pready, pslverr, hold_ack, rx_stop, data_irq, event_irq;
  logic [7:0]  tx_byte;
  wire         master_req_set, slave_tx_set, slave_rx_set, slave_tx_enable, locked;
  wire         broadcast, lost_broadcast, is_receiver, in_data_field, addressed;
  wire         frame_start, addr_ack_master, addr_slave_req, from_lock_unit, ctl_valid;
  wire         len_valid, bit_start, bit_edge, parity_err, nack_hdr, tx_load;
  wire         data_ack_slot, data_acked, rx_byte_valid;
  wire [3:0]   ctl_code;
  wire [7:0]   len_rx, bit_min, bit_max, rx_byte;
  int          err_count  = 0;
  int          num_checks = 0;
  int          ev_cnt     = 0;
  int          dq_cnt     = 0;
  int          e0;
  // strobes: 1 master addr, 2 slave req, 3 control, 7 parity, 8 nack, 10 ack slot, F timing
  sbirq_row_t  rows [17] = '{
    '{9'h000, 4'h1, 8'h00, 8'h20}, '{9'h004, 4'h2, 8'h00, 8'h20},
    '{9'h084, 4'h2, 8'h00, 8'h00}, '{9'h086, 4'h2, 8'h00, 8'h20},
    '{9'h014, 4'h3, 8'h00, 8'h10}, '{9'h014, 4'h3, 8'h04, 8'h10},
    '{9'h014, 4'h3, 8'h05, 8'h10}, '{9'h014, 4'h3, 8'h06, 8'h10},
    '{9'h014, 4'h3, 8'h01, 8'h00}, '{9'h010, 4'h7, 8'h00, 8'h40},
    '{9'h018, 4'h7, 8'h00, 8'h00}, '{9'h058, 4'h7, 8'h00, 8'h40},
    '{9'h078, 4'h7, 8'h00, 8'h00}, '{9'h000, 4'h8, 8'h00, 8'h40},
    '{9'h000, 4'hF, 8'h02, 8'h40}, '{9'h000, 4'hF, 8'h07, 8'h00},
    '{9'h001, 4'hA, 8'h00, 8'h08}};
  ////////////////////////////////////////
  sbirq_core uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .master_req_set, .slave_tx_set, .slave_rx_set, .slave_tx_enable, .locked, .broadcast,
    .lost_broadcast, .is_receiver, .in_data_field, .addressed, .frame_start,
    .addr_ack_master, .addr_slave_req, .from_lock_unit, .ctl_valid, .ctl_code, .len_valid,
    .len_rx, .bit_start, .bit_edge, .bit_min, .bit_max, .parity_err, .nack_hdr, .tx_load,
    .data_ack_slot, .data_acked, .rx_byte_valid, .rx_byte, .hold_ack, .rx_stop, .tx_byte,
    .data_irq, .event_irq);
  sbirq_bus_model eng (
    .pclk, .master_req_set, .slave_tx_set, .slave_rx_set, .slave_tx_enable, .locked,
    .broadcast, .lost_broadcast, .is_receiver, .in_data_field, .addressed, .frame_start,
    .addr_ack_master, .addr_slave_req, .from_lock_unit, .ctl_valid, .ctl_code, .len_valid,
    .len_rx, .bit_start, .bit_edge, .bit_min, .bit_max, .parity_err, .nack_hdr, .tx_load,
    .data_ack_slot, .data_acked, .rx_byte_valid, .rx_byte);
  ////////////////////////////////////////
  initial begin
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (event_irq === 1'b1) ev_cnt <= ev_cnt + 1;
    if (data_irq === 1'b1) dq_cnt <= dq_cnt + 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {16'h0000, a};
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(q, {24'h000000, e});
    chk({31'h0, pslverr}, 32'h0);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    complete_run();
  end
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      e0 = ev_cnt;
      eng.set_lv(rows[i].lv);
      if (rows[i].ev == 4'hF) eng.bit_run(rows[i].v);
      else eng.pulse(rows[i].ev, rows[i].v);
      repeat (4) @(posedge pclk);
      rd(A_FL, rows[i].fl);
      chk(32'(ev_cnt - e0), {31'h0, rows[i].fl != 8'h00});
      apb(1'b1, A_FL, 8'h00);
      eng.pulse(12 + i % 3, 8'h00);
      rd(A_FL, 8'h00);
      eng.set_lv(9'h000);
      $display("row %0d done", i);
    end
    // second reset and register reset values, unmapped read
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_SC, 8'h01);
    rd(A_FL, 8'h00);
    rd(A_SR, 8'h40);
    rd(A_FC, 8'h20);
    rd(A_TL, 8'h01);
    rd(16'hFFF0, 8'h00);
    eng.set_lv(9'h180);
    rd(A_SR, 8'h54);
    $display("reset and report test done");
    // full frame of nacked slots
    eng.set_lv(9'h000);
    eng.pulse(4, 8'h05);
    eng.pulse(0, 8'h00);
    repeat (32) eng.pulse(10, 8'h00);
    repeat (4) @(posedge pclk);
    rd(A_SC, 8'h05);
    rd(A_FC, 8'h00);
    rd(A_FL, 8'h04);
    eng.pulse(14, 8'h00);
    repeat (2) @(posedge pclk);
    rd(A_FL, 8'h00);
    $display("frame test done");
    // length 00 means 256 bytes
    eng.pulse(0, 8'h00);
    eng.pulse(4, 8'h00);
    rd(A_SC, 8'h00);
    eng.set_lv(9'h001);
    eng.pulse(10, 8'h00);
    repeat (3) @(posedge pclk);
    rd(A_SC, 8'hFF);
    rd(A_FL, 8'h00);
    $display("wide counter test done");
    // status request presets the length
    apb(1'b1, A_TL, 8'h07);
    eng.set_lv(9'h014);
    eng.pulse(3, 8'h00);
    repeat (3) @(posedge pclk);
    rd(A_TL, 8'h01);
    apb(1'b1, A_FL, 8'h00);
    $display("status length test done");
    // unread byte then a second byte: overrun
    eng.pulse(0, 8'h00);
    eng.set_lv(9'h01C);
    e0 = dq_cnt;
    eng.pulse(11, 8'hAA);
    eng.pulse(11, 8'h55);
    repeat (3) @(posedge pclk);
    chk({31'h0, hold_ack}, 32'h1);
    chk(32'(dq_cnt - e0), 32'h1);
    eng.set_lv(9'h01D);
    eng.pulse(10, 8'h00);
    repeat (2) @(posedge pclk);
    rd(A_SC, 8'h01);
    rd(A_FC, 8'h1F);
    rd(A_DT, 8'hAA);
    $display("overrun test done");
    // broadcast overrun: error, stop, data kept
    eng.set_lv(9'h05C);
    eng.pulse(11, 8'h11);
    eng.pulse(11, 8'h22);
    eng.pulse(11, 8'h33);
    repeat (2) @(posedge pclk);
    chk({31'h0, rx_stop}, 32'h1);
    rd(A_FL, 8'h40);
    rd(A_SR, 8'h42);
    rd(A_DT, 8'h22);
    apb(1'b1, A_FL, 8'h00);
    eng.pulse(0, 8'h00);
    repeat (2) @(posedge pclk);
    chk({31'h0, rx_stop}, 32'h0);
    $display("broadcast overrun test done");
    // transmit: byte moved, then underrun
    eng.set_lv(9'h008);
    eng.pulse(4, 8'h03);
    apb(1'b1, A_DT, 8'h3C);
    e0 = dq_cnt;
    eng.pulse(9, 8'h00);
    repeat (2) @(posedge pclk);
    chk({24'h000000, tx_byte}, 32'h0000_003C);
    chk(32'(dq_cnt - e0), 32'h1);
    eng.pulse(9, 8'h00);
    repeat (2) @(posedge pclk);
    rd(A_FL, 8'h40);
    $display("transmit test done");
    complete_run();
  end
endmodule // serial_bus_irq_status_counters_test
